// *** hdl/art3_pkg.sv ***
// package: register map, field layout and constants of the auto-reload timer
`default_nettype none
package art3_pkg;

	// register byte addresses
	localparam logic [7:0] ART3_ADDR_CONTROL = 8'h91;
	localparam logic [7:0] ART3_ADDR_RLD_LO  = 8'h92;
	localparam logic [7:0] ART3_ADDR_RLD_HI  = 8'h93;
	localparam logic [7:0] ART3_ADDR_CNT_LO  = 8'h94;
	localparam logic [7:0] ART3_ADDR_CNT_HI  = 8'h95;

	// control register field positions
	localparam int ART3_BIT_HI_FLAG  = 7;
	localparam int ART3_BIT_LO_FLAG  = 6;
	localparam int ART3_BIT_LO_IEN   = 5;
	localparam int ART3_BIT_CAP_EN   = 4;
	localparam int ART3_BIT_SPLIT    = 3;
	localparam int ART3_BIT_RUN      = 2;
	localparam int ART3_BIT_XSEL_HI  = 1;
	localparam int ART3_BIT_XSEL_LO  = 0;

	// reset values
	localparam logic [7:0] ART3_RST_CONTROL = 8'h00;
	localparam logic [7:0] ART3_RST_RELOAD  = 8'h00;
	localparam logic [7:0] ART3_RST_COUNT   = 8'h00;

	// byte rollover value
	localparam logic [7:0] ART3_BYTE_MAX = 8'hff;

	// auxiliary clock select codes
	localparam logic [1:0] ART3_XSEL_CMP_A = 2'h0;
	localparam logic [1:0] ART3_XSEL_CMP_B = 2'h1;
	localparam logic [1:0] ART3_XSEL_OSC   = 2'h2;

	// system clock divider for the external count clock
	localparam int ART3_EXT_DIV = 12;

	// software register bus request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} art3_bus_s;

	// control register layout
	typedef struct packed {
		logic       high_overflow_flag;
		logic       low_overflow_flag;
		logic       low_irq_enable;
		logic       capture_enable_bit;
		logic       split_mode_select;
		logic       run_control_bit;
		logic [1:0] aux_clock_select;
	} art3_ctrl_s;

endpackage : art3_pkg
`default_nettype wire

// *** hdl/art3_sync.sv ***
// module: two-flop synchroniser for asynchronous level inputs
`default_nettype none
`timescale 1ns/10ps
module art3_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             mclk,
	input  wire logic             rstn,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;

	// first stage feeds only the second stage
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule : art3_sync
`default_nettype wire

// *** hdl/art3_div.sv ***
// module: divider that emits a one-cycle enable pulse every DIV cycles
`default_nettype none
`timescale 1ns/10ps
module art3_div #(
	parameter int DIV = 12
) (
	input  wire logic mclk,
	input  wire logic rstn,
	output logic      tick
);
	localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);

	logic [CW-1:0] cnt_q;

	// free-running count, wraps at DIV
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cnt_q <= '0;
		end else if (cnt_q == LAST) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + CW'(1);
		end
	end

	// pulse on the wrap cycle
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			tick <= 1'b0;
		end else begin
			tick <= (cnt_q == LAST);
		end
	end
endmodule : art3_div
`default_nettype wire

// *** hdl/art3_timer.sv ***
// module: auto-reload timer with split 8-bit mode and capture
//
// The strobed register port was chosen for this implementation.
`default_nettype none
`timescale 1ns/10ps
module art3_timer #(
	parameter int EXT_DIV = art3_pkg::ART3_EXT_DIV
) (
	input  wire logic                 mclk,
	input  wire logic                 rstn,
	input  wire art3_pkg::art3_bus_s  bus_req,
	output logic [7:0]                bus_rdata,
	input  wire logic                 high_byte_clock_pick,
	input  wire logic                 low_byte_clock_pick,
	input  wire logic                 cmp1_out,
	input  wire logic                 ext_osc_div8,
	output logic                      high_overflow_flag,
	output logic                      low_overflow_flag,
	output logic                      low_irq_enable,
	output logic [15:0]               count_value
);
	import art3_pkg::*;

	art3_ctrl_s ctrl_q;
	logic [7:0] rld_lo_q;
	logic [7:0] rld_hi_q;
	logic [7:0] cnt_lo_q;
	logic [7:0] cnt_hi_q;
	logic       ext_tick;
	logic [1:0] trig_sync;
	logic       trig_prev_q;
	logic       trig_level;
	logic       cap_evt;
	logic       tick_lo;
	logic       tick_hi;
	logic       ovf_lo;
	logic       ovf_hi;
	logic       ovf_16;
	logic       set_hi_flag;
	logic       set_lo_flag;
	logic       wr_ctrl;
	logic       wr_rld_lo;
	logic       wr_rld_hi;
	logic       wr_cnt_lo;
	logic       wr_cnt_hi;
	logic [7:0] rdata_d;

	// system_clock_signal/12 external count clock as an enable pulse
	art3_div #(
		.DIV (EXT_DIV)
	) u_div (
		.mclk (mclk),
		.rstn (rstn),
		.tick (ext_tick)
	);

	// comparator and oscillator/8 pass two flops before use
	art3_sync #(
		.WIDTH (2)
	) u_sync (
		.mclk     (mclk),
		.rstn     (rstn),
		.async_in ({ext_osc_div8, cmp1_out}),
		.sync_out (trig_sync)
	);

	// capture trigger source chosen by the select field
	always_comb begin
		unique case (ctrl_q.aux_clock_select)
			ART3_XSEL_CMP_A: trig_level = trig_sync[0];
			ART3_XSEL_CMP_B: trig_level = trig_sync[0];
			ART3_XSEL_OSC:   trig_level = trig_sync[1];
			default:         trig_level = 1'b0;
		endcase
	end

	// rising-edge detect on the synchronised trigger
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			trig_prev_q <= 1'b0;
		end else begin
			trig_prev_q <= trig_level;
		end
	end

	assign cap_evt = ctrl_q.capture_enable_bit && trig_level && !trig_prev_q;

	// write decode
	assign wr_ctrl   = bus_req.wr && (bus_req.addr == ART3_ADDR_CONTROL);
	assign wr_rld_lo = bus_req.wr && (bus_req.addr == ART3_ADDR_RLD_LO);
	assign wr_rld_hi = bus_req.wr && (bus_req.addr == ART3_ADDR_RLD_HI);
	assign wr_cnt_lo = bus_req.wr && (bus_req.addr == ART3_ADDR_CNT_LO);
	assign wr_cnt_hi = bus_req.wr && (bus_req.addr == ART3_ADDR_CNT_HI);

	// per-byte count enables: external clock or every system clock
	always_comb begin
		if (ctrl_q.split_mode_select) begin
			tick_lo = low_byte_clock_pick ? 1'b1 : ext_tick;
			tick_hi = ctrl_q.run_control_bit
				&& (high_byte_clock_pick ? 1'b1 : ext_tick);
		end else begin
			tick_lo = ctrl_q.run_control_bit
				&& (low_byte_clock_pick ? 1'b1 : ext_tick);
			tick_hi = 1'b0;
		end
	end

	// overflow detection for both layouts
	assign ovf_lo = tick_lo && (cnt_lo_q == ART3_BYTE_MAX);
	assign ovf_16 = !ctrl_q.split_mode_select && ovf_lo
		&& (cnt_hi_q == ART3_BYTE_MAX);
	assign ovf_hi = ctrl_q.split_mode_select
		&& tick_hi && (cnt_hi_q == ART3_BYTE_MAX);

	// flag set sources
	assign set_hi_flag = ovf_16 || ovf_hi || cap_evt;
	assign set_lo_flag = ovf_lo;

	// control register; hardware set wins over software clear
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ctrl_q <= art3_ctrl_s'(ART3_RST_CONTROL);
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= art3_ctrl_s'(bus_req.wdata);
			end
			if (set_hi_flag) begin
				ctrl_q.high_overflow_flag <= 1'b1;
			end
			if (set_lo_flag) begin
				ctrl_q.low_overflow_flag <= 1'b1;
			end
		end
	end

	// reload low byte: software value or captured count
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rld_lo_q <= ART3_RST_RELOAD;
		end else if (cap_evt) begin
			rld_lo_q <= cnt_lo_q;
		end else if (wr_rld_lo) begin
			rld_lo_q <= bus_req.wdata;
		end
	end

	// reload high byte: software value or captured count
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rld_hi_q <= ART3_RST_RELOAD;
		end else if (cap_evt) begin
			rld_hi_q <= cnt_hi_q;
		end else if (wr_rld_hi) begin
			rld_hi_q <= bus_req.wdata;
		end
	end

	// low count byte: software write, reload, or increment
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cnt_lo_q <= ART3_RST_COUNT;
		end else if (wr_cnt_lo) begin
			cnt_lo_q <= bus_req.wdata;
		end else if (ovf_16 || (ctrl_q.split_mode_select && ovf_lo)) begin
			cnt_lo_q <= rld_lo_q;
		end else if (tick_lo) begin
			cnt_lo_q <= cnt_lo_q + 8'h01;
		end
	end

	// high count byte: carry in 16-bit mode, own counter in split mode
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cnt_hi_q <= ART3_RST_COUNT;
		end else if (wr_cnt_hi) begin
			cnt_hi_q <= bus_req.wdata;
		end else if (ovf_16 || ovf_hi) begin
			cnt_hi_q <= rld_hi_q;
		end else if (!ctrl_q.split_mode_select && ovf_lo) begin
			cnt_hi_q <= cnt_hi_q + 8'h01;
		end else if (tick_hi) begin
			cnt_hi_q <= cnt_hi_q + 8'h01;
		end
	end

	// read mux; unmapped addresses read zero
	always_comb begin
		rdata_d = 8'h00;
		unique case (bus_req.addr)
			ART3_ADDR_CONTROL: rdata_d = ctrl_q;
			ART3_ADDR_RLD_LO:  rdata_d = rld_lo_q;
			ART3_ADDR_RLD_HI:  rdata_d = rld_hi_q;
			ART3_ADDR_CNT_LO:  rdata_d = cnt_lo_q;
			ART3_ADDR_CNT_HI:  rdata_d = cnt_hi_q;
			default:           rdata_d = 8'h00;
		endcase
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			bus_rdata <= 8'h00;
		end else if (bus_req.rd) begin
			bus_rdata <= rdata_d;
		end else begin
			bus_rdata <= 8'h00;
		end
	end

	// status outputs straight from registers
	assign high_overflow_flag = ctrl_q.high_overflow_flag;
	assign low_overflow_flag  = ctrl_q.low_overflow_flag;
	assign low_irq_enable     = ctrl_q.low_irq_enable;
	assign count_value        = {cnt_hi_q, cnt_lo_q};

endmodule : art3_timer
`default_nettype wire

// *** tb/art3_timer_monitor.sv ***
// checker: port-level properties of the auto-reload timer
`default_nettype none
`timescale 1ns/10ps
module art3_timer_monitor #(
	parameter int EXT_DIV = 12
) (
	input wire logic                mclk,
	input wire logic                rstn,
	input wire art3_pkg::art3_bus_s bus_req,
	input wire logic [7:0]          bus_rdata,
	input wire logic                high_byte_clock_pick,
	input wire logic                low_byte_clock_pick,
	input wire logic                cmp1_out,
	input wire logic                ext_osc_div8,
	input wire logic                high_overflow_flag,
	input wire logic                low_overflow_flag,
	input wire logic                low_irq_enable,
	input wire logic [15:0]         count_value
);
	import art3_pkg::*;
	logic wr_ctl;
	logic wr_lo;
	logic wr_hi;

	// software writes that may legally move flags or count bytes
	assign wr_ctl = bus_req.wr && bus_req.addr == ART3_ADDR_CONTROL;
	assign wr_lo  = bus_req.wr && bus_req.addr == ART3_ADDR_CNT_LO;
	assign wr_hi  = bus_req.wr && bus_req.addr == ART3_ADDR_CNT_HI;

	// properties on the single clock domain
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	sequence quiet_s;
		!low_byte_clock_pick && !bus_req.wr;
	endsequence
	sequence slow_s;
		!high_byte_clock_pick && !low_byte_clock_pick && !bus_req.wr;
	endsequence
	sequence lo_wrap_s;
		count_value[7:0] == ART3_BYTE_MAX && !wr_lo ##1 count_value[7:0] != ART3_BYTE_MAX;
	endsequence
	sequence hi_wrap_s;
		count_value[15:8] == ART3_BYTE_MAX && !wr_hi ##1 count_value[15:8] != ART3_BYTE_MAX;
	endsequence

	rdata_idle_a:
	assert property (!bus_req.rd |=> bus_rdata == 8'h00) else $error("read data not idle");
	cnt_read_a:
	assert property (bus_req.rd && bus_req.addr == ART3_ADDR_CNT_LO
		|=> bus_rdata == $past(count_value[7:0])) else $error("count low read wrong");
	hi_read_a:
	assert property (bus_req.rd && bus_req.addr == ART3_ADDR_CNT_HI
		|=> bus_rdata == $past(count_value[15:8])) else $error("count high read wrong");
	unmapped_read_a:
	assert property (bus_req.rd && (bus_req.addr < ART3_ADDR_CONTROL || bus_req.addr > 8'h95)
		|=> bus_rdata == 8'h00) else $error("unmapped read not zero");
	hflag_sticky_a:
	assert property (high_overflow_flag && !wr_ctl |=> high_overflow_flag)
		else $error("high flag dropped");
	lflag_sticky_a:
	assert property (low_overflow_flag && !wr_ctl |=> low_overflow_flag)
		else $error("low flag dropped");
	lo_wrap_flag_a:
	assert property (lo_wrap_s |-> low_overflow_flag) else $error("low wrap without flag");
	hi_wrap_flag_a:
	assert property (hi_wrap_s |-> high_overflow_flag) else $error("high wrap without flag");
	tick_spacing_a:
	assert property (quiet_s ##1 (quiet_s and $changed(count_value[7:0]))
		|=> $stable(count_value[7:0])) else $error("divided clock counted twice");
	hi_spacing_a:
	assert property (slow_s ##1 (slow_s and $changed(count_value[15:8]))
		|=> $stable(count_value[15:8])) else $error("high byte counted twice");
endmodule : art3_timer_monitor

bind art3_timer art3_timer_monitor #(.EXT_DIV(EXT_DIV)) u_art3_mon (.mclk(mclk), .rstn(rstn),
	.bus_req(bus_req), .bus_rdata(bus_rdata), .high_byte_clock_pick(high_byte_clock_pick),
	.low_byte_clock_pick(low_byte_clock_pick), .cmp1_out(cmp1_out),
	.ext_osc_div8(ext_osc_div8), .high_overflow_flag(high_overflow_flag),
	.low_overflow_flag(low_overflow_flag), .low_irq_enable(low_irq_enable),
	.count_value(count_value));
`default_nettype wire

// *** tb/art3_timer_bench.sv ***
// bench: register-level tests of the auto-reload timer
`default_nettype none
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin errors++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module art3_timer_bench;
	import art3_pkg::*;
	logic       mclk  = 1'b0;
	logic       rstn  = 1'b0;
	logic       hpick = 1'b1;
	logic       lpick = 1'b1;
	logic [1:0] trg   = 2'b00;
	art3_bus_s  bus   = '0;
	logic [7:0] rdata;
	logic       hflag;
	logic       lflag;
	logic       lien;
	logic [15:0] cnt;
	logic [15:0] v;
	int         errors = 0;
	int         tests_run = 0;
	int         i;

	// clock and device under test
	always #12.5 mclk = ~mclk;
	art3_timer #(.EXT_DIV(12)) DUT (.mclk(mclk), .rstn(rstn), .bus_req(bus), .bus_rdata(rdata),
		.high_byte_clock_pick(hpick), .low_byte_clock_pick(lpick), .cmp1_out(trg[0]),
		.ext_osc_div8(trg[1]), .high_overflow_flag(hflag), .low_overflow_flag(lflag),
		.low_irq_enable(lien), .count_value(cnt));

	// bus tasks, flag wait and verdict
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		bus.addr <= a;
		bus.wdata <= d;
		bus.wr <= 1'b1;
		@(posedge mclk);
		bus.wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge mclk);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge mclk);
		bus.rd <= 1'b0;
		#1;
		`CHK(rdata, e)
	endtask : rd
	task automatic wfl(input logic h);
		for (int k = 0; k < 400; k++) begin
			@(posedge mclk);
			#1;
			if ((h ? hflag : lflag) === 1'b1) return;
		end
		`CHK(h ? hflag : lflag, 1'b1)
	endtask : wfl
	task automatic stop_test;
		if (errors == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : stop_test

	// watchdog
	initial begin
		repeat (20000) @(posedge mclk);
		errors++;
		stop_test();
	end

	// test sequence
	initial begin
		repeat (8) @(posedge mclk);
		rstn <= 1'b1;
		`CHK(cnt, 16'h0000)
		for (i = 0; i < 5; i++) rd(ART3_ADDR_CONTROL + 8'(i), 8'h00);
		wr(ART3_ADDR_RLD_LO, 8'h34);
		wr(ART3_ADDR_RLD_HI, 8'h12);
		rd(ART3_ADDR_RLD_LO, 8'h34);
		rd(ART3_ADDR_RLD_HI, 8'h12);
		wr(8'h96, 8'h55);
		rd(8'h96, 8'h00);
		wr(ART3_ADDR_CNT_HI, 8'hff);
		wr(ART3_ADDR_CNT_LO, 8'hfd);
		rd(ART3_ADDR_CNT_LO, 8'hfd);
		rd(ART3_ADDR_CNT_HI, 8'hff);
		wr(ART3_ADDR_CONTROL, 8'h04);
		wfl(1'b1);
		`CHK(cnt, 16'h1234)
		`CHK(lflag, 1'b1)
		repeat (20) @(posedge mclk);
		#1;
		`CHK(hflag, 1'b1)
		wr(ART3_ADDR_CONTROL, 8'h00);
		repeat (2) @(posedge mclk);
		#1;
		v = cnt;
		`CHK({hflag, lflag}, 2'b00)
		repeat (20) @(posedge mclk);
		#1;
		`CHK(cnt, v)
		// split mode: low runs free, high waits for run
		wr(ART3_ADDR_RLD_LO, 8'hf0);
		wr(ART3_ADDR_RLD_HI, 8'ha0);
		wr(ART3_ADDR_CNT_HI, 8'hff);
		wr(ART3_ADDR_CNT_LO, 8'hfe);
		wr(ART3_ADDR_CONTROL, 8'h08);
		wfl(1'b0);
		`CHK(cnt, 16'hfff0)
		`CHK(hflag, 1'b0)
		wr(ART3_ADDR_CONTROL, 8'h0c);
		wfl(1'b1);
		`CHK(cnt[15:8], 8'ha0)
		// capture for each trigger select code, wrong source first
		for (i = 0; i < 3; i++) begin
			wr(ART3_ADDR_CONTROL, 8'h10 | 8'(i));
			wr(ART3_ADDR_CNT_LO, 8'h5a);
			wr(ART3_ADDR_CNT_HI, 8'(i));
			@(posedge mclk);
			trg <= (i == 2) ? 2'b01 : 2'b10;
			repeat (6) @(posedge mclk);
			#1;
			`CHK(hflag, 1'b0)
			@(posedge mclk);
			trg <= 2'b11;
			repeat (3) @(posedge mclk);
			#1;
			`CHK(hflag, 1'b1)
			rd(ART3_ADDR_RLD_LO, 8'h5a);
			rd(ART3_ADDR_RLD_HI, 8'(i));
			rd(ART3_ADDR_CONTROL, 8'h90 | 8'(i));
			@(posedge mclk);
			trg <= 2'b00;
		end
		// select code 11 has no capture trigger
		wr(ART3_ADDR_CONTROL, 8'h13);
		@(posedge mclk);
		trg <= 2'b11;
		repeat (5) @(posedge mclk);
		#1;
		`CHK(hflag, 1'b0)
		@(posedge mclk);
		trg <= 2'b00;
		// divided clock: one step every twelve cycles
		lpick <= 1'b0;
		wr(ART3_ADDR_CNT_LO, 8'h00);
		wr(ART3_ADDR_CONTROL, 8'h24);
		#1;
		`CHK(lien, 1'b1)
		v = cnt;
		for (i = 0; i < 30 && cnt === v; i++) begin
			@(posedge mclk);
			#1;
		end
		v = cnt;
		repeat (12) @(posedge mclk);
		#1;
		`CHK(cnt, v + 16'h0001)
		// split mode, both bytes on the divided clock
		hpick <= 1'b0;
		wr(ART3_ADDR_CONTROL, 8'h0c);
		#1;
		`CHK(lien, 1'b0)
		v = cnt;
		for (i = 0; i < 30 && cnt === v; i++) begin
			@(posedge mclk);
			#1;
		end
		v = cnt;
		repeat (12) @(posedge mclk);
		#1;
		`CHK(cnt, v + 16'h0101)
		stop_test();
	end
endmodule : art3_timer_bench
`default_nettype wire
